// ### svcfe_cfg.svh
// Purpose: constants for the servo command input front end
// Assumes: included by the modules that need the figures; the package does not include it
// Notes: stop selections are 2-bit and other settings 4-bit codes as printed; the mode letters A and b are 4'ha and 4'hb
`ifndef SVCFE_CFG_SVH
`define SVCFE_CFG_SVH

// stop selections
`define SVCFE_ALM_DB_HOLD 2'h0
`define SVCFE_ALM_DB_FREE 2'h1
`define SVCFE_ALM_COAST 2'h2
`define SVCFE_ALM_DEF 2'h2
`define SVCFE_OT_USE_ALM 2'h0
`define SVCFE_OT_DECEL_LOCK 2'h1
`define SVCFE_OT_DECEL_FREE 2'h2
`define SVCFE_OT_DEF 2'h0

// command pulse format
`define SVCFE_FMT_DEF 4'h1
`define SVCFE_FMT_NEG_BASE 4'h5
`define SVCFE_FMT_MAX 4'h9

// control mode codes
`define SVCFE_MODE_SPEED 4'h0
`define SVCFE_MODE_POS 4'h1
`define SVCFE_MODE_TORQUE 4'h2
`define SVCFE_MODE_INT 4'h3
`define SVCFE_MODE_INT_SPEED 4'h4
`define SVCFE_MODE_INT_POS 4'h5
`define SVCFE_MODE_INT_TRQ 4'h6
`define SVCFE_MODE_POS_SPEED 4'h7
`define SVCFE_MODE_POS_TRQ 4'h8
`define SVCFE_MODE_SPEED_TRQ 4'h9
`define SVCFE_MODE_SPEED_LOCK 4'ha
`define SVCFE_MODE_POS_INHIBIT 4'hb
`define SVCFE_MODE_DEF 4'h1

// drive prohibit allocation
`define SVCFE_ALLOC_ON 4'h7
`define SVCFE_ALLOC_OFF 4'h8
`define SVCFE_ALLOC_DEF 4'h8

// synchronised pin vector layout
`define SVCFE_PIN_W 9
`define SVCFE_PIN_A 0
`define SVCFE_PIN_B 1
`define SVCFE_PIN_RUN 2
`define SVCFE_PIN_SEQ2 3
`define SVCFE_PIN_FWD_PROH 4
`define SVCFE_PIN_REV_PROH 5
`define SVCFE_PIN_ALM_RST 6
`define SVCFE_PIN_SEQ6 7
`define SVCFE_PIN_SEQ7 8

`define SVCFE_POS_W 32
`endif

// ### svcfe_pkg.sv
// Purpose: types shared by the servo command input front end
// Assumes: svcfe_cfg.svh holds all figures
// Notes: none
`default_nettype none
package svcfe_pkg;
  typedef enum logic [2:0] {
    SVCFE_FMT_PULSE_DIR = 3'h0,
    SVCFE_FMT_FWD_REV = 3'h1,
    SVCFE_FMT_QUAD_X1 = 3'h2,
    SVCFE_FMT_QUAD_X2 = 3'h3,
    SVCFE_FMT_QUAD_X4 = 3'h4
  } svcfe_fmt_t;

  typedef enum logic [1:0] {
    SVCFE_EFF_SPEED = 2'h0,
    SVCFE_EFF_POS = 2'h1,
    SVCFE_EFF_TORQUE = 2'h2,
    SVCFE_EFF_INT = 2'h3
  } svcfe_eff_t;

  // gray along run -> stopping -> stopped
  typedef enum logic [1:0] {
    SVCFE_ST_RUN = 2'b00,
    SVCFE_ST_BRAKE = 2'b01,
    SVCFE_ST_STOPPED = 2'b11,
    SVCFE_ST_DECEL = 2'b10
  } svcfe_stop_t;
endpackage
`default_nettype wire

// ### svcfe_pulse_if.sv
// Purpose: carrier between the top and the command pulse decoder
// Assumes: one clock domain
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface svcfe_pulse_if;
  import svcfe_pkg::*;
  logic pin_a;
  logic pin_b;
  svcfe_fmt_t fmt;
  logic neg_logic;
  logic step;
  logic step_fwd;
  modport dec (input pin_a, input pin_b, input fmt, input neg_logic,
    output step, output step_fwd);
  modport top (output pin_a, output pin_b, output fmt, output neg_logic,
    input step, input step_fwd);
endinterface
`default_nettype wire

// ### svcfe_pulse_dec.sv
// Purpose: turns the command pulse lines into single command increments
// Assumes: pin_a and pin_b are already synchronised to core_clk
// Notes: in forward/reverse mode simultaneous rising edges on both lines cancel
`timescale 1ns/10ps
`default_nettype none
`include "svcfe_cfg.svh"
module svcfe_pulse_dec
  import svcfe_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  svcfe_pulse_if.dec pif
);
  logic la;
  logic lb;
  logic prev_a_ff;
  logic prev_b_ff;
  logic step_ff;
  logic step_fwd_ff;
  logic nxt_step;
  logic nxt_step_fwd;
  logic edge_a;
  logic edge_b;

  ////////////////////////////////////////////////////////////////////////////
  // negative logic inverts both lines before any edge is seen
  assign la = pif.pin_a ^ pif.neg_logic;
  assign lb = pif.pin_b ^ pif.neg_logic;
  assign edge_a = la ^ prev_a_ff;
  assign edge_b = lb ^ prev_b_ff;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      prev_a_ff <= 1'b0;
      prev_b_ff <= 1'b0;
    end
    else
    begin
      prev_a_ff <= la;
      prev_b_ff <= lb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a leads b means forward; x1 counts a rising, x2 both a edges, x4 all
  always_comb
  begin
    nxt_step = 1'b0;
    nxt_step_fwd = 1'b1;
    unique case (pif.fmt)
      SVCFE_FMT_PULSE_DIR:
      begin
        nxt_step = edge_a & la;
        nxt_step_fwd = lb;
      end
      SVCFE_FMT_FWD_REV:
      begin
        nxt_step = (edge_a & la) ^ (edge_b & lb);
        nxt_step_fwd = edge_a & la;
      end
      SVCFE_FMT_QUAD_X1:
      begin
        nxt_step = edge_a & la;
        nxt_step_fwd = la ^ lb;
      end
      SVCFE_FMT_QUAD_X2:
      begin
        nxt_step = edge_a;
        nxt_step_fwd = la ^ lb;
      end
      SVCFE_FMT_QUAD_X4:
      begin
        // a lost pair (both lines flip at once) is dropped, not guessed
        nxt_step = edge_a ^ edge_b;
        nxt_step_fwd = edge_a ? (la ^ lb) : ~(la ^ lb);
      end
      default:
      begin
        nxt_step = 1'b0;
        nxt_step_fwd = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      step_ff <= 1'b0;
      step_fwd_ff <= 1'b1;
    end
    else
    begin
      step_ff <= nxt_step;
      step_fwd_ff <= nxt_step_fwd;
    end
  end

  assign pif.step = step_ff;
  assign pif.step_fwd = step_fwd_ff;
endmodule
`default_nettype wire

// ### svcfe_top.sv
// Purpose: command side of a servo drive: pulse decode, stop selection, input routing
// Assumes: settings ports are static; motor status inputs come from core_clk logic
// Notes: pins are active high after synchronisation; pulse lines a and b are active low in formats 5-9
//
// How it works
// - servo-off/alarm stop: 0 brake held, 1 brake released, 2 coast; default 2
// - overtravel stop: 0 alarm method, 1 decel then lock, 2 decel then free
// - servolock after overtravel in position control disables the position loop
// - torque control ignores overtravel selection, uses servo-off/alarm stop only
// - drive prohibit inputs default to always inactive until allocation changes
// - pulse format 0-9, default 1; 5-9 are 0-4 in negative logic
// - quadrature x4 gives four increments per pulse, x2 gives two
// - input 2 is gain reduce or rotation direction in 0, 1, 3-6, by mode and speed selects; unused in 2
// - input 2 is mode switch in 7-9, position lock in A, pulse inhibit in b
// - inputs 6/7 are current limits in 0-2, 7-b; speed selects in 3-6
// - first output is position done in position mode, speed match in speed
// - run, alarm reset, turning and ready lines are fixed in every mode
// - control mode field 0 to b selects the operating mode, default 1
`timescale 1ns/10ps
`default_nettype none
`include "svcfe_cfg.svh"
module svcfe_top
  import svcfe_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] alarm_stop_select,
  input wire logic [1:0] overtravel_stop_select,
  input wire logic [3:0] cmd_pulse_format,
  input wire logic [3:0] control_mode_select,
  input wire logic [3:0] fwd_prohibit_alloc,
  input wire logic [3:0] rev_prohibit_alloc,
  input wire logic [`SVCFE_PIN_W-1:0] seq_pins,
  input wire logic servo_on_req,
  input wire logic alarm_active,
  input wire logic motor_stopped,
  input wire logic motor_turning,
  input wire logic at_position,
  input wire logic at_speed,
  input wire logic drive_ready,
  output logic cmd_step,
  output logic cmd_step_fwd,
  output logic [`SVCFE_POS_W-1:0] cmd_position,
  output logic gain_reduce_in,
  output logic rotation_dir_in,
  output logic ctrl_mode_switch_in,
  output logic position_lock_in,
  output logic pulse_inhibit_in,
  output logic fwd_drive_prohibit_in,
  output logic rev_drive_prohibit_in,
  output logic fwd_current_limit_in,
  output logic rev_current_limit_in,
  output logic speed_select_1_in,
  output logic speed_select_2_in,
  output logic run_cmd_in,
  output logic alarm_reset_in,
  output logic [1:0] eff_mode,
  output logic servo_enable,
  output logic dyn_brake_on,
  output logic estop_torque_en,
  output logic servo_lock,
  output logic pos_loop_disable,
  output logic position_done_out,
  output logic speed_match_out,
  output logic motor_turning_out,
  output logic servo_ready_out
);
  logic [`SVCFE_PIN_W-1:0] sync1_ff;
  logic [`SVCFE_PIN_W-1:0] sync2_ff;
  logic cfg_loaded_ff;
  logic [1:0] alm_sel_ff;
  logic [1:0] ot_sel_ff;
  logic [3:0] fmt_ff;
  logic [3:0] mode_ff;
  logic [3:0] fwd_alloc_ff;
  logic [3:0] rev_alloc_ff;
  svcfe_stop_t stop_st_ff;
  svcfe_stop_t nxt_stop_st;
  logic ot_stop_ff;
  logic nxt_ot_stop;
  logic [`SVCFE_POS_W-1:0] pos_ff;
  svcfe_eff_t eff;
  svcfe_fmt_t fmt_kind;
  logic seq2;
  logic spd_any;
  logic fwd_proh;
  logic rev_proh;
  logic overtravel;
  logic alarm_stop;
  logic ot_use_alm;
  logic step_ok;
  svcfe_pulse_if pif ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < `SVCFE_PIN_W; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= seq_pins[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // settings: defaults during reset, captured once right after release
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg_loaded_ff <= 1'b0;
      alm_sel_ff <= `SVCFE_ALM_DEF;
      ot_sel_ff <= `SVCFE_OT_DEF;
      fmt_ff <= `SVCFE_FMT_DEF;
      mode_ff <= `SVCFE_MODE_DEF;
      fwd_alloc_ff <= `SVCFE_ALLOC_DEF;
      rev_alloc_ff <= `SVCFE_ALLOC_DEF;
    end
    else if (!cfg_loaded_ff)
    begin
      // out-of-range codes keep the default rather than invent a behaviour
      cfg_loaded_ff <= 1'b1;
      if (alarm_stop_select <= `SVCFE_ALM_COAST)
        alm_sel_ff <= alarm_stop_select;
      if (overtravel_stop_select <= `SVCFE_OT_DECEL_FREE)
        ot_sel_ff <= overtravel_stop_select;
      if (cmd_pulse_format <= `SVCFE_FMT_MAX)
        fmt_ff <= cmd_pulse_format;
      if (control_mode_select <= `SVCFE_MODE_POS_INHIBIT)
        mode_ff <= control_mode_select;
      fwd_alloc_ff <= fwd_prohibit_alloc;
      rev_alloc_ff <= rev_prohibit_alloc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared input routing by control mode
  assign seq2 = sync2_ff[`SVCFE_PIN_SEQ2];
  assign spd_any = sync2_ff[`SVCFE_PIN_SEQ6] | sync2_ff[`SVCFE_PIN_SEQ7];

  always_comb
  begin
    gain_reduce_in = 1'b0;
    rotation_dir_in = 1'b0;
    ctrl_mode_switch_in = 1'b0;
    position_lock_in = 1'b0;
    pulse_inhibit_in = 1'b0;
    fwd_current_limit_in = 1'b0;
    rev_current_limit_in = 1'b0;
    speed_select_1_in = 1'b0;
    speed_select_2_in = 1'b0;
    unique case (mode_ff)
      `SVCFE_MODE_SPEED, `SVCFE_MODE_POS:
        gain_reduce_in = seq2;
      `SVCFE_MODE_INT, `SVCFE_MODE_INT_SPEED, `SVCFE_MODE_INT_POS:
      begin
        gain_reduce_in = seq2 & ~spd_any;
        rotation_dir_in = seq2 & spd_any;
      end
      `SVCFE_MODE_INT_TRQ:
        rotation_dir_in = seq2 & spd_any;
      `SVCFE_MODE_POS_SPEED, `SVCFE_MODE_POS_TRQ, `SVCFE_MODE_SPEED_TRQ:
        ctrl_mode_switch_in = seq2;
      `SVCFE_MODE_SPEED_LOCK:
        position_lock_in = seq2;
      `SVCFE_MODE_POS_INHIBIT:
        pulse_inhibit_in = seq2;
      default:
        gain_reduce_in = 1'b0;
    endcase
    if (mode_ff >= `SVCFE_MODE_INT && mode_ff <= `SVCFE_MODE_INT_TRQ)
    begin
      speed_select_1_in = sync2_ff[`SVCFE_PIN_SEQ6];
      speed_select_2_in = sync2_ff[`SVCFE_PIN_SEQ7];
    end
    else
    begin
      fwd_current_limit_in = sync2_ff[`SVCFE_PIN_SEQ6];
      rev_current_limit_in = sync2_ff[`SVCFE_PIN_SEQ7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective mode; switched pairs take the second mode when switched
  always_comb
  begin
    eff = SVCFE_EFF_POS;
    unique case (mode_ff)
      `SVCFE_MODE_SPEED, `SVCFE_MODE_SPEED_LOCK: eff = SVCFE_EFF_SPEED;
      `SVCFE_MODE_POS, `SVCFE_MODE_POS_INHIBIT: eff = SVCFE_EFF_POS;
      `SVCFE_MODE_TORQUE: eff = SVCFE_EFF_TORQUE;
      `SVCFE_MODE_INT: eff = SVCFE_EFF_INT;
      `SVCFE_MODE_INT_SPEED: eff = spd_any ? SVCFE_EFF_INT : SVCFE_EFF_SPEED;
      `SVCFE_MODE_INT_POS: eff = spd_any ? SVCFE_EFF_INT : SVCFE_EFF_POS;
      `SVCFE_MODE_INT_TRQ: eff = spd_any ? SVCFE_EFF_INT : SVCFE_EFF_TORQUE;
      `SVCFE_MODE_POS_SPEED: eff = seq2 ? SVCFE_EFF_SPEED : SVCFE_EFF_POS;
      `SVCFE_MODE_POS_TRQ: eff = seq2 ? SVCFE_EFF_TORQUE : SVCFE_EFF_POS;
      `SVCFE_MODE_SPEED_TRQ: eff = seq2 ? SVCFE_EFF_TORQUE : SVCFE_EFF_SPEED;
      default: eff = SVCFE_EFF_POS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive prohibit: 7 forces active, 8 forces inactive, else the pin
  always_comb
  begin
    fwd_proh = sync2_ff[`SVCFE_PIN_FWD_PROH];
    rev_proh = sync2_ff[`SVCFE_PIN_REV_PROH];
    if (fwd_alloc_ff == `SVCFE_ALLOC_ON)
      fwd_proh = 1'b1;
    else if (fwd_alloc_ff == `SVCFE_ALLOC_OFF)
      fwd_proh = 1'b0;
    if (rev_alloc_ff == `SVCFE_ALLOC_ON)
      rev_proh = 1'b1;
    else if (rev_alloc_ff == `SVCFE_ALLOC_OFF)
      rev_proh = 1'b0;
  end

  assign overtravel = fwd_proh | rev_proh;
  assign alarm_stop = ~servo_on_req | alarm_active | ~run_cmd_in;
  // torque control always stops by the servo-off/alarm method
  assign ot_use_alm = (eff == SVCFE_EFF_TORQUE) | (ot_sel_ff == `SVCFE_OT_USE_ALM);

  ////////////////////////////////////////////////////////////////////////////
  // stop sequencer; alarm/servo-off takes priority over overtravel
  always_comb
  begin
    nxt_stop_st = stop_st_ff;
    nxt_ot_stop = ot_stop_ff;
    unique case (stop_st_ff)
      SVCFE_ST_RUN:
      begin
        if (alarm_stop || (overtravel && ot_use_alm))
        begin
          nxt_stop_st = SVCFE_ST_BRAKE;
          nxt_ot_stop = 1'b0;
        end
        else if (overtravel)
        begin
          nxt_stop_st = SVCFE_ST_DECEL;
          nxt_ot_stop = 1'b1;
        end
      end
      SVCFE_ST_BRAKE:
        if (motor_stopped)
          nxt_stop_st = SVCFE_ST_STOPPED;
      SVCFE_ST_DECEL:
      begin
        if (alarm_stop)
        begin
          nxt_stop_st = SVCFE_ST_BRAKE;
          nxt_ot_stop = 1'b0;
        end
        else if (motor_stopped)
          nxt_stop_st = SVCFE_ST_STOPPED;
      end
      SVCFE_ST_STOPPED:
      begin
        if (ot_stop_ff && alarm_stop)
          nxt_ot_stop = 1'b0;
        else if (!alarm_stop && !overtravel)
          nxt_stop_st = SVCFE_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !cfg_loaded_ff)
    begin
      stop_st_ff <= SVCFE_ST_STOPPED;
      ot_stop_ff <= 1'b0;
    end
    else
    begin
      stop_st_ff <= nxt_stop_st;
      ot_stop_ff <= nxt_ot_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      servo_enable <= 1'b0;
      dyn_brake_on <= 1'b0;
      estop_torque_en <= 1'b0;
      servo_lock <= 1'b0;
      pos_loop_disable <= 1'b0;
    end
    else
    begin
      servo_enable <= (stop_st_ff == SVCFE_ST_RUN) || (stop_st_ff == SVCFE_ST_DECEL) ||
        (stop_st_ff == SVCFE_ST_STOPPED && ot_stop_ff &&
        ot_sel_ff == `SVCFE_OT_DECEL_LOCK);
      // coast never closes the brake; selection 0 keeps it after the stop
      dyn_brake_on <= (stop_st_ff == SVCFE_ST_BRAKE && alm_sel_ff != `SVCFE_ALM_COAST) ||
        (stop_st_ff == SVCFE_ST_STOPPED && !ot_stop_ff &&
        alm_sel_ff == `SVCFE_ALM_DB_HOLD);
      estop_torque_en <= stop_st_ff == SVCFE_ST_DECEL;
      servo_lock <= (stop_st_ff == SVCFE_ST_STOPPED && ot_stop_ff &&
        ot_sel_ff == `SVCFE_OT_DECEL_LOCK) ||
        (stop_st_ff == SVCFE_ST_RUN && position_lock_in);
      pos_loop_disable <= stop_st_ff == SVCFE_ST_STOPPED && ot_stop_ff &&
        ot_sel_ff == `SVCFE_OT_DECEL_LOCK && eff == SVCFE_EFF_POS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command pulse decode; the host must match the selected format
  assign fmt_kind = svcfe_fmt_t'((fmt_ff >= `SVCFE_FMT_NEG_BASE) ?
    3'(fmt_ff - `SVCFE_FMT_NEG_BASE) : fmt_ff[2:0]);
  assign pif.pin_a = sync2_ff[`SVCFE_PIN_A];
  assign pif.pin_b = sync2_ff[`SVCFE_PIN_B];
  assign pif.fmt = fmt_kind;
  assign pif.neg_logic = fmt_ff >= `SVCFE_FMT_NEG_BASE;

  svcfe_pulse_dec u_dec (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pif(pif)
  );

  // pulses count only while position control runs and no inhibit
  assign step_ok = pif.step && eff == SVCFE_EFF_POS && stop_st_ff == SVCFE_ST_RUN &&
    !pulse_inhibit_in;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cmd_step <= 1'b0;
      cmd_step_fwd <= 1'b1;
      pos_ff <= '0;
    end
    else
    begin
      cmd_step <= step_ok;
      cmd_step_fwd <= pif.step_fwd;
      if (step_ok)
        pos_ff <= pif.step_fwd ? pos_ff + 1'b1 : pos_ff - 1'b1;
    end
  end

  assign cmd_position = pos_ff;

  ////////////////////////////////////////////////////////////////////////////
  // fixed lines and the mode dependent output pair
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      run_cmd_in <= 1'b0;
      alarm_reset_in <= 1'b0;
      motor_turning_out <= 1'b0;
      servo_ready_out <= 1'b0;
      position_done_out <= 1'b0;
      speed_match_out <= 1'b0;
      eff_mode <= 2'h1;
    end
    else
    begin
      run_cmd_in <= sync2_ff[`SVCFE_PIN_RUN];
      alarm_reset_in <= sync2_ff[`SVCFE_PIN_ALM_RST];
      motor_turning_out <= motor_turning;
      servo_ready_out <= drive_ready && !alarm_active;
      position_done_out <= eff == SVCFE_EFF_POS && at_position;
      speed_match_out <= (eff == SVCFE_EFF_SPEED || eff == SVCFE_EFF_INT) && at_speed;
      eff_mode <= eff;
    end
  end

  assign fwd_drive_prohibit_in = fwd_proh;
  assign rev_drive_prohibit_in = rev_proh;
endmodule
`default_nettype wire

// ### svcfe_host_model.sv
// Purpose: host controller model that drives the two command pulse lines
// Assumes: tasks are called just after a core_clk rising edge
// Notes: every level is held four clocks, well above the two-clock minimum
`timescale 1ns/10ps
`default_nettype none
module svcfe_host_model (
  input wire logic core_clk,
  output logic pin_a,
  output logic pin_b
);
  logic neg = 1'b0;
  initial {pin_a, pin_b} = 2'h0;

  task automatic lv(input logic a, input logic b);
    pin_a <= a ^ neg;
    pin_b <= b ^ neg;
    repeat (4) @(posedge core_clk);
  endtask

  // four levels per pulse, pairs of a then b, first pair in the top bits
  task automatic send(input int f, input int n, input logic fwd);
    logic [7:0] p;
    neg = f >= 5;
    p = f % 5 >= 2 ? (fwd ? 8'hb4 : 8'h78) : f % 5 == 1 ? (fwd ? 8'ha0 : 8'h50) :
      (fwd ? 8'hf5 : 8'ha0);
    // direction line settles before the first pulse edge
    lv(1'b0, f % 5 == 0 && fwd);
    for (int i = 0; i < n; i++)
      for (int j = 3; j >= 0; j--)
        lv(p[2 * j + 1], p[2 * j]);
  endtask
endmodule
`default_nettype wire

// ### svcfe_top_asserts.sv
// Purpose: port-level checks of the command front end
// Assumes: setting ports only change around a reset
// Notes: bound to every svcfe_top
`timescale 1ns/10ps
`default_nettype none
`include "svcfe_cfg.svh"
module svcfe_top_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] alarm_stop_select,
  input wire logic [1:0] overtravel_stop_select,
  input wire logic [3:0] fwd_prohibit_alloc,
  input wire logic servo_on_req,
  input wire logic alarm_active,
  input wire logic motor_stopped,
  input wire logic cmd_step,
  input wire logic cmd_step_fwd,
  input wire logic [`SVCFE_POS_W-1:0] cmd_position,
  input wire logic fwd_drive_prohibit_in,
  input wire logic [1:0] eff_mode,
  input wire logic servo_enable,
  input wire logic dyn_brake_on,
  input wire logic estop_torque_en,
  input wire logic servo_lock,
  input wire logic pos_loop_disable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_step_count: assert property (
    cmd_step |-> cmd_position == $past(cmd_position) + (cmd_step_fwd ? 32'h1 : 32'hffff_ffff))
    else $error("step not one count");
  a_off_stop: assert property (
    $fell(servo_on_req) && servo_enable |-> ##[1:3] !servo_enable) else $error("no stop");
  a_brake_hold: assert property (
    alarm_stop_select == 2'h0 && dyn_brake_on && !servo_on_req |=> dyn_brake_on)
    else $error("brake let go");
  a_brake_free: assert property (
    (alarm_stop_select == 2'h1 && !servo_on_req && motor_stopped)[*4] |-> !dyn_brake_on)
    else $error("brake kept");
  a_torque_ot: assert property (
    eff_mode == 2'h2 && $stable(eff_mode) && !estop_torque_en |=> !estop_torque_en)
    else $error("torque mode decel");
  a_loop_off: assert property (
    pos_loop_disable |-> servo_lock && eff_mode == 2'h1) else $error("loop off wrongly");
  a_ot_decel: assert property (
    $rose(fwd_drive_prohibit_in) && servo_enable && !estop_torque_en && servo_on_req &&
    !alarm_active && overtravel_stop_select != 2'h0 && eff_mode != 2'h2
    |=> eff_mode == 2'h2 or ##[0:3] estop_torque_en) else $error("no decel");
  a_prohibit_off: assert property (
    fwd_prohibit_alloc == 4'h8 && $past(rst_n, 2) |-> !fwd_drive_prohibit_in)
    else $error("prohibit active");
endmodule
bind svcfe_top svcfe_top_asserts i_chk (.*);
`default_nettype wire

// ### svcfe_tb.sv
// Purpose: self-checking bench for the command front end
// Assumes: settings are set while reset is held, then changed after release to show they are captured once
// Notes: a mode sweep checks routing and stopping, a format sweep the pulses
`timescale 1ns/10ps
`default_nettype none
`include "svcfe_cfg.svh"
module testbench;
  import svcfe_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] alarm_stop_select = 2'h2, overtravel_stop_select = 2'h0;
  logic [3:0] cmd_pulse_format = 4'h1, control_mode_select = 4'h1;
  logic [3:0] fwd_prohibit_alloc = 4'h8, rev_prohibit_alloc = 4'h8;
  logic [6:0] hi = 7'h01;
  logic servo_on_req = 1'b1, alarm_active = 1'b0, motor_stopped = 1'b0;
  logic motor_turning = 1'b0, at_position = 1'b0, at_speed = 1'b0, drive_ready = 1'b0;
  wire logic pa, pb;
  wire logic [`SVCFE_PIN_W-1:0] seq_pins = {hi, pb, pa};
  logic cmd_step, cmd_step_fwd, gain_reduce_in, rotation_dir_in, ctrl_mode_switch_in;
  logic position_lock_in, pulse_inhibit_in, fwd_drive_prohibit_in, rev_drive_prohibit_in;
  logic fwd_current_limit_in, rev_current_limit_in, speed_select_1_in, speed_select_2_in;
  logic run_cmd_in, alarm_reset_in, servo_enable, dyn_brake_on, estop_torque_en;
  logic servo_lock, pos_loop_disable, position_done_out, speed_match_out;
  logic motor_turning_out, servo_ready_out;
  logic [1:0] eff_mode;
  logic [`SVCFE_POS_W-1:0] cmd_position;
  logic [31:0] rs = 32'h47f7_3e22;
  logic [31:0] r;
  int n_fail = 0;
  int cmp_count = 0;
  wire logic [2:0] md_o = {ctrl_mode_switch_in, position_lock_in, pulse_inhibit_in};
  wire logic [3:0] lim_o = {fwd_current_limit_in, rev_current_limit_in, speed_select_1_in,
    speed_select_2_in};
  wire logic [3:0] fix_o = {run_cmd_in, alarm_reset_in, motor_turning_out, servo_ready_out};
  wire logic [4:0] st_o = {servo_enable, dyn_brake_on, estop_torque_en, servo_lock,
    pos_loop_disable};

  svcfe_top i_dut (.*);
  svcfe_host_model i_host (.core_clk(core_clk), .pin_a(pa), .pin_b(pb));

  initial forever #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // settings are taken at the first edge after release
  task automatic rst();
    rst_n <= 1'b0;
    w(12);
    rst_n <= 1'b1;
    w(8);
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int e, n, x;
    logic s2, s6, s7, sp, ss, ot, br;
    logic [31:0] ex;
    @(posedge core_clk);
    for (int m = 0; m < 12; m++)
    begin
      r = rnd();
      control_mode_select <= m[3:0];
      alarm_stop_select <= r[1:0] % 2'h3;
      overtravel_stop_select <= r[3:2] % 2'h3;
      fwd_prohibit_alloc <= r[5] ? 4'h0 : (r[4] ? 4'h7 : 4'h8);
      rev_prohibit_alloc <= r[6] ? 4'h0 : 4'h8;
      {servo_on_req, alarm_active, motor_stopped} <= 3'h4;
      hi <= 7'h01;
      rst();
      control_mode_select <= 4'h2;
      for (int i = 0; i < 4; i++)
      begin
        r = rnd();
        hi <= {r[5:0], 1'b1};
        {motor_turning, at_position, at_speed, drive_ready} <= r[11:8];
        w(6);
        {s2, s6, s7} = {hi[1], hi[5], hi[6]};
        ss = s6 | s7;
        sp = m >= 3 && m <= 6;
        e = m == 0 || m == 10 ? 0 : m == 1 || m == 11 ? 1 : m == 2 ? 2 : m == 3 ? 3 :
          m <= 6 ? (ss ? 3 : m - 4) : m == 7 ? (s2 ? 0 : 1) : m == 8 ? (s2 ? 2 : 1) : (s2 ? 2 : 0);
        chk("eff_mode", e, eff_mode);
        ex = {s2 && (m <= 1 || (m >= 3 && m <= 5 && !ss)), s2 && sp && ss};
        chk("seq2_gain_dir", ex, {gain_reduce_in, rotation_dir_in});
        ex = {s2 && m >= 7 && m <= 9, s2 && m == 10, s2 && m == 11};
        chk("seq2_mode", ex, md_o);
        ex = sp ? {2'h0, s6, s7} : {s6, s7, 2'h0};
        chk("seq67", ex, lim_o);
        ex = {fwd_prohibit_alloc == 4'h7 || (fwd_prohibit_alloc == 4'h0 && hi[2]),
          rev_prohibit_alloc == 4'h0 && hi[3]};
        chk("prohibit", ex, {fwd_drive_prohibit_in, rev_drive_prohibit_in});
        chk("fixed", {1'b1, hi[4], motor_turning, drive_ready}, fix_o);
        ex = {e == 1 && at_position, (e == 0 || e == 3) && at_speed};
        chk("out_pair", ex, {position_done_out, speed_match_out});
      end
      // a forced prohibit never lets the drive run
      if (fwd_prohibit_alloc == 4'h7)
        continue;
      hi[3:2] <= 2'h0;
      motor_stopped <= 1'b1;
      w(5);
      motor_stopped <= 1'b0;
      w(8);
      chk("running", 1, servo_enable);
      ot = r[7] && fwd_prohibit_alloc == 4'h0;
      if (ot)
        hi[2] <= 1'b1;
      else if (r[8])
        alarm_active <= 1'b1;
      else
        servo_on_req <= 1'b0;
      w(5);
      br = !ot || e == 2 || overtravel_stop_select == 2'h0;
      ex = br ? {1'b0, alarm_stop_select != 2'h2, 3'h0} : 5'h14;
      chk("stopping", ex, st_o);
      motor_stopped <= 1'b1;
      w(5);
      ex = br ? {1'b0, alarm_stop_select == 2'h0, 3'h0} :
        overtravel_stop_select == 2'h1 ? {4'h9, e == 1} : 5'h0;
      chk("stopped", ex, st_o);
    end
    {fwd_prohibit_alloc, rev_prohibit_alloc} <= 8'h88;
    for (int f = 0; f < 10; f++)
    begin
      // settings and pin levels are set while reset is held; the format changes again after release
      rst_n <= 1'b0;
      cmd_pulse_format <= f[3:0];
      control_mode_select <= 4'h1;
      {servo_on_req, alarm_active, motor_stopped} <= 3'h4;
      hi <= 7'h01;
      i_host.send(f, 0, 1'b0);
      rst();
      cmd_pulse_format <= 4'h9 - f[3:0];
      n = 1 + rnd() % 4;
      x = f % 5 == 4 ? 4 : f % 5 == 3 ? 2 : 1;
      i_host.send(f, n, 1'b1);
      w(8);
      chk("pos_fwd", x * n, cmd_position);
      i_host.send(f, n, 1'b0);
      w(8);
      chk("pos_back", 0, cmd_position);
    end
    print_verdict();
  end

  // the sweeps need up to about 2600 cycles; allow several times that
  initial
  begin
    #200_000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
